// ### rtl/nvc_ctrl.sv
// Nested vectored interrupt controller, Wishbone classic slave.
// Assumes peripheral requests and processor handshakes run on clk.
//
// Overview of operation
// RL1: Per-source enable bits, set and cleared by software.
// RL2: Global gate blocks request, keeps enables.
// RL3: Gate state readable before and after change.
// RL4: Sleep-after-handler control signals sleep on exit.
// RL5: Grouping register reports preemption bit count.
// RL6: Non-zero threshold masks levels at or above it.
// RL7: Only upper three priority bits used.
// RL8: Smaller priority number is more urgent.
// RL9: Vector table base readable by software.
// RL10: Per-source enable state reads back non-zero.
// RL11: Software pend dispatches when priority allows.
// RL12: Disabled pending source is never dispatched.
// RL13: Equal priority: lowest source number first.
// RL14: Equal preemption level never preempts; tail-chains.
// RL15: Software clears pending, discarding unserviced request.
// RL16: Grouping three to seven behave identically.
// RL17: Present best source with base-plus-index vector.
`timescale 1ns/1ps
`default_nettype none
`include "nvc_defs.svh"

module nvc_ctrl
    import nvc_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // Wishbone classic slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [31:0]          wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // Peripheral interrupt sources
    input  wire logic [`NVC_NSRC-1:0] src_irq,
    // Processor core
    output nvc_cpu_req_t              cpu,
    input  wire logic                 irq_ack,
    input  wire logic                 irq_done,
    output logic                      sleep_on_exit,
    output logic                      sleep_enter
);

    localparam int NS = `NVC_NSRC;

    // Lowest masked priority among set bits; strict compare keeps the
    // lowest source number on a tie.
    function automatic nvc_pick_t pick(input logic [NS-1:0] vec,
                                       input nvc_prio_arr_t pr,
                                       input nvc_prio_t msk);
        nvc_pick_t r;
        nvc_prio_t best;
        r = '0;
        best = '0;
        for (int i = 0; i < NS; i++) begin
            if (vec[i] && (!r.found || (pr[i] & msk) < best)) begin
                r.found = 1'b1;
                r.idx = i[`NVC_IDXW-1:0];
                best = pr[i] & msk;
            end
        end
        return r;
    endfunction

    // State
    logic [NS-1:0]   en;
    logic [NS-1:0]   pend;
    logic [NS-1:0]   active;
    logic [NS-1:0]   src_q;
    logic            gate;
    logic            sleep_flag;
    logic [2:0]      grp;
    logic [7:0]      thresh;
    logic [21:0]     vtbase;
    logic [31:0]     dat_q;
    logic            prio_rd_q;
    logic            ack_q;

    // Bus decode
    wire             acc    = wb_cyc_i & wb_stb_i & ~ack_q;
    wire             wr     = acc & wb_we_i;
    wire [7:0]       a      = wb_adr_i[7:0];
    wire [31:0]      wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0]      wbits  = wb_dat_i & wmask;
    wire             is_prio = (a >= `NVC_A_PRIO_LO) && (a <= `NVC_A_PRIO_HI);
    wire [`NVC_IDXW-1:0] prio_idx = 5'(a[7:2] - 6'h10);
    wire             wr_ens  = wr && a == `NVC_A_EN_SET;
    wire             wr_enc  = wr && a == `NVC_A_EN_CLR;
    wire             wr_ps   = wr && a == `NVC_A_PEND_SET;
    wire             wr_pc   = wr && a == `NVC_A_PEND_CLR;
    wire             wr_ctl  = wr && a == `NVC_A_CTRL;
    wire             wr_thr  = wr && a == `NVC_A_THRESH && wb_sel_i[0];
    wire             wr_vt   = wr && a == `NVC_A_VTBASE;
    wire             wr_gop  = wr && a == `NVC_A_GATE_OPEN;
    wire             wr_gcl  = wr && a == `NVC_A_GATE_CLS;
    wire             wr_prio = wr && is_prio && wb_sel_i[0];

    // Priority store
    nvc_prio_arr_t   prio_all;
    nvc_prio_t       prio_rdata;

    nvc_prio_mem u_prio (
        .clk   (clk),
        .rst_b (rst_b),
        .we    (wr_prio),
        .waddr (prio_idx),
        .wdata (wb_dat_i[`NVC_PRIO_LSB +: `NVC_PW]), // RL7
        .raddr (prio_idx),
        .rdata (prio_rdata),
        .all   (prio_all)
    );

    // Preemption field of the 3-bit level; settings 3..7 all keep every bit
    wire nvc_prio_t  pmask   = (grp == 3'h0) ? 3'b000 :             // RL16
                               (grp == 3'h1) ? 3'b100 :
                               (grp == 3'h2) ? 3'b110 : 3'b111;     // RL16
    wire nvc_prio_t  thr_lvl = thresh[`NVC_PRIO_LSB +: `NVC_PW];    // RL7

    // Per-source eligibility and handshake decode
    logic [NS-1:0]   elig;
    logic [NS-1:0]   ack_hit;
    logic [NS-1:0]   done_hit;
    nvc_pick_t       cand;
    nvc_pick_t       run;

    assign cand = pick(elig, prio_all, 3'b111);                     // RL8 RL13
    assign run  = pick(active, prio_all, pmask);

    genvar i;
    generate
        for (i = 0; i < NS; i++) begin : g_src
            wire masked = (thr_lvl != 3'h0) && (prio_all[i] >= thr_lvl); // RL6
            assign elig[i]     = pend[i] & en[i] & ~masked;         // RL12
            // An ack with no request standing is ignored
            assign ack_hit[i]  = irq_ack && cpu.req && cpu.index == 5'(i);
            assign done_hit[i] = irq_done && run.found &&
                                 run.idx == 5'(i);
        end
    endgenerate

    // Running preemption level; a candidate must be strictly more urgent
    wire [3:0]       run_lvl  = run.found ? {1'b0, prio_all[run.idx] & pmask}
                                          : `NVC_LVL_NONE;
    wire [3:0]       cand_lvl = {1'b0, prio_all[cand.idx] & pmask};
    wire             preempt_ok = cand.found && cand_lvl < run_lvl; // RL14 RL11
    wire             next_req = gate & preempt_ok & ~irq_ack;       // RL2
    wire [31:0]      next_vector = {vtbase, 3'h0, cand.idx, 2'h0};  // RL17

    // Pending: hardware and software sets win over every clear
    wire [NS-1:0]    src_rise  = src_irq & ~src_q;
    wire [NS-1:0]    pend_set  = src_rise | (wr_ps ? wbits : '0);   // RL11
    wire [NS-1:0]    pend_clr  = (wr_pc ? wbits : '0) | ack_hit;    // RL15
    wire [NS-1:0]    next_pend = (pend & ~pend_clr) | pend_set;
    wire [NS-1:0]    next_en   = (en | (wr_ens ? wbits : '0)) &
                                 ~(wr_enc ? wbits : '0);            // RL1
    wire [NS-1:0]    next_active = (active & ~done_hit) | ack_hit;
    wire             last_exit = irq_done && (active & ~done_hit) == '0;

    // Read data
    logic [31:0]     rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        case (a)
            `NVC_A_EN_SET, `NVC_A_EN_CLR:     rd_word = en;         // RL10
            `NVC_A_PEND_SET, `NVC_A_PEND_CLR: rd_word = pend;
            `NVC_A_ACTIVE:                    rd_word = active;
            `NVC_A_CTRL: begin
                rd_word[`NVC_CTL_GATE]  = gate;                     // RL3
                rd_word[`NVC_CTL_SLEEP] = sleep_flag;
                rd_word[`NVC_CTL_GRP_LSB +: 3] = grp;               // RL5
            end
            `NVC_A_THRESH:   rd_word[7:0] = thresh;
            `NVC_A_VTBASE:   rd_word[31:`NVC_VT_LSB] = vtbase;      // RL9
            `NVC_A_STATUS: begin
                rd_word[`NVC_ST_REQ] = cpu.req;
                rd_word[`NVC_ST_IDX_LSB +: `NVC_IDXW] = cpu.index;
                rd_word[3:0] = run_lvl;
            end
            `NVC_A_VECTOR:   rd_word = cpu.vector;
            `NVC_A_GATE_OPEN, `NVC_A_GATE_CLS: rd_word[0] = gate;   // RL3
            default:         rd_word = 32'h0000_0000;
        endcase
    end

    // Bus slave: one wait state, unmapped reads give zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_q     <= 1'b0;
            dat_q     <= 32'h0000_0000;
            prio_rd_q <= 1'b0;
        end else begin
            ack_q     <= acc;
            prio_rd_q <= acc & is_prio;
            if (acc) begin
                dat_q <= rd_word;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = prio_rd_q ? {24'h00_0000, prio_rdata, 5'h00} : dat_q;

    // Configuration
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gate       <= `NVC_RST_GATE;
            sleep_flag <= `NVC_RST_SLEEP;
            grp        <= `NVC_RST_GRP;
            thresh     <= `NVC_RST_THRESH;
            vtbase     <= `NVC_RST_VTBASE;
        end else begin
            if (wr_ctl && wb_sel_i[0]) begin
                gate       <= wb_dat_i[`NVC_CTL_GATE];              // RL2
                sleep_flag <= wb_dat_i[`NVC_CTL_SLEEP];             // RL4
            end else if (wr_gop) begin
                gate <= 1'b1;                                       // RL2
            end else if (wr_gcl) begin
                gate <= 1'b0;                                       // RL2
            end
            if (wr_ctl && wb_sel_i[1]) begin
                grp <= wb_dat_i[`NVC_CTL_GRP_LSB +: 3];             // RL5
            end
            if (wr_thr) begin
                thresh <= wb_dat_i[7:0];                            // RL6
            end
            if (wr_vt) begin
                vtbase <= wb_dat_i[31:`NVC_VT_LSB];                 // RL9
            end
        end
    end

    // Source, enable, pending and active state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            src_q  <= '0;
            en     <= '0;
            pend   <= '0;
            active <= '0;
        end else begin
            src_q  <= src_irq;
            en     <= next_en;
            pend   <= next_pend;
            active <= next_active;
        end
    end

    // Processor side; the request drops for the cycle after an ack so
    // that a stale index is never offered twice
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu         <= '0;
            sleep_enter <= 1'b0;
        end else begin
            cpu.req     <= next_req;
            cpu.index   <= cand.idx;
            cpu.vector  <= next_vector;
            sleep_enter <= sleep_flag & last_exit;                  // RL4
        end
    end

    assign sleep_on_exit = sleep_flag;                              // RL4

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    en_set_a: assert property (wr_ens && wbits[0] |=> en[0]) // RL1
        else $error("enable set did not take");
    en_clear_a: assert property (wr_enc && wbits[3] && !wr_ens |=> !en[3]) // RL1
        else $error("enable clear did not take");
    gate_block_a: assert property (!gate |=> !cpu.req) // RL2
        else $error("request passed a closed gate");
    gate_read_a: assert property (wr_gcl |=> !gate) // RL3
        else $error("gate state not closed after close");
    mask_thr_a: assert property (cand.found && thr_lvl != 3'h0 |->
                                 prio_all[cand.idx] < thr_lvl) // RL6
        else $error("masked level chosen");
    dis_nodisp_a: assert property (cand.found |-> en[cand.idx] && pend[cand.idx]) // RL12
        else $error("disabled source chosen");
    pend_set_a: assert property (wr_ps && wbits[1] |=> pend[1] ##1 1'b1) // RL11
        else $error("software pend lost");
    pend_clr_a: assert property (wr_pc && wbits[2] && !wr_ps && !src_rise[2]
                                 |=> !pend[2]) // RL15
        else $error("pend clear did not take");
    nest_a: assert property (next_req |-> cand_lvl < run_lvl) // RL14
        else $error("equal level preempted");
    vec_addr_a: assert property (cpu.req |->
                                 cpu.vector[9:0] == {3'h0, cpu.index, 2'h0}) // RL17
        else $error("vector does not match index");
    ack_drop_a: assert property (irq_ack |=> !cpu.req) // RL17
        else $error("request held across ack");

    // Bus ack stays one cycle wide; requests and acks follow source eligibility, pending and active state
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) // RL17
        else $error("bus ack held two cycles");
    ack_take_a: assert property (irq_ack && cpu.req |=> active[$past(cpu.index)]) // RL11
        else $error("taken source not marked active");
    pend_ack_a: assert property (irq_ack && cpu.req && !pend_set[cpu.index] |=> // RL11
                                 !pend[$past(cpu.index)])
        else $error("taken source still pending");
    req_elig_a: assert property (cpu.req |-> $past(elig[cand.idx])) // RL12
        else $error("request raised for an ineligible source");

    // Enables move only under their own registers
    gate_keep_en_a: assert property (wr_gop || wr_gcl |=> en == $past(en)) // RL2
        else $error("gate change altered enables");
    en_keep_a: assert property (!wr_ens && !wr_enc |=> en == $past(en)) // RL1
        else $error("enables changed without a write");

    sleep_exit_a: assert property (sleep_flag && last_exit |=> sleep_enter) // RL4
        else $error("no sleep after last handler");
    sleep_only_a: assert property (sleep_enter |-> $past(sleep_flag && last_exit)) // RL4
        else $error("sleep without last handler exit");

    // Register writes land at the request edge
    grp_write_a: assert property (wr_ctl && wb_sel_i[1] |=> // RL5
                                  grp == $past(wb_dat_i[`NVC_CTL_GRP_LSB +: 3]))
        else $error("grouping write lost");
    thr_write_a: assert property (wr_thr |=> thresh == $past(wb_dat_i[7:0])) // RL6
        else $error("threshold write lost");
    vt_write_a: assert property (wr_vt |=> vtbase == $past(wb_dat_i[31:`NVC_VT_LSB])) // RL9
        else $error("vector base write lost");
    prio_write_a: assert property (wr_prio |=> // RL7
                                   prio_all[$past(prio_idx)] ==
                                   $past(wb_dat_i[`NVC_PRIO_LSB +: `NVC_PW]))
        else $error("priority level not stored from the top bits");

    thr_zero_a: assert property (thr_lvl == 3'h0 && pend[0] && en[0] |-> elig[0]) // RL6
        else $error("zero threshold still masks");
    tie_low_a: assert property (cand.found && cand.idx != 5'h00 |-> // RL13
                                !(elig[0] && prio_all[0] == prio_all[cand.idx]))
        else $error("tie not won by lowest source");
    chain_a: assert property (run.found && cand.found && cand_lvl == run_lvl // RL14
                              |-> !next_req)
        else $error("equal preemption level raised a request");
    grp_full_a: assert property (grp >= 3'h3 |-> pmask == 3'b111) // RL16
        else $error("wide grouping drops priority bits");

endmodule

`default_nettype wire

// ### rtl/nvc_defs.svh
// Constants of the vectored interrupt controller: sizes, register byte
// offsets, field positions and reset values.
// Assumes inclusion by bare name from the rtl folder.
`ifndef NVC_DEFS_SVH
`define NVC_DEFS_SVH

`define NVC_NSRC        32
`define NVC_IDXW        5
`define NVC_PW          3

// Register byte offsets (Wishbone, 32-bit words)
`define NVC_A_EN_SET    8'h00
`define NVC_A_EN_CLR    8'h04
`define NVC_A_PEND_SET  8'h08
`define NVC_A_PEND_CLR  8'h0C
`define NVC_A_ACTIVE    8'h10
`define NVC_A_CTRL      8'h14
`define NVC_A_THRESH    8'h18
`define NVC_A_VTBASE    8'h1C
`define NVC_A_STATUS    8'h20
`define NVC_A_VECTOR    8'h24
`define NVC_A_GATE_OPEN 8'h28
`define NVC_A_GATE_CLS  8'h2C
`define NVC_A_PRIO_LO   8'h40
`define NVC_A_PRIO_HI   8'hBC

// Field positions
`define NVC_CTL_GATE    0
`define NVC_CTL_SLEEP   1
`define NVC_CTL_GRP_LSB 8
`define NVC_PRIO_LSB    5
`define NVC_VT_LSB      10
`define NVC_ST_REQ      31
`define NVC_ST_IDX_LSB  16

// Reset values
`define NVC_RST_GATE    1'b0
`define NVC_RST_SLEEP   1'b0
`define NVC_RST_GRP     3'h0
`define NVC_RST_THRESH  8'h00
`define NVC_RST_VTBASE  22'h000000
`define NVC_RST_PRIO    3'h0

// Running level when no handler is active, above every preemption level
`define NVC_LVL_NONE    4'h8

`endif

// ### rtl/nvc_pkg.sv
// Types shared by the vectored interrupt controller files.
// Assumes nvc_defs.svh sits in the same folder.
`include "nvc_defs.svh"

package nvc_pkg;

    typedef logic [`NVC_PW-1:0] nvc_prio_t;

    typedef logic [`NVC_NSRC-1:0][`NVC_PW-1:0] nvc_prio_arr_t;

    typedef struct packed {
        logic                 found;
        logic [`NVC_IDXW-1:0] idx;
    } nvc_pick_t;

    // Request presented to the processor core
    typedef struct packed {
        logic                 req;
        logic [`NVC_IDXW-1:0] index;
        logic [31:0]          vector;
    } nvc_cpu_req_t;

endpackage

// ### rtl/nvc_prio_mem.sv
// Per-source priority store: one 3-bit level per source.
// All levels leave in parallel for arbitration; the software read port
// answers from a register one edge after the address.
`timescale 1ns/1ps
`default_nettype none
`include "nvc_defs.svh"

module nvc_prio_mem
    import nvc_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // Write port
    input  wire logic                 we,
    input  wire logic [`NVC_IDXW-1:0] waddr,
    input  wire nvc_prio_t            wdata,
    // Read port
    input  wire logic [`NVC_IDXW-1:0] raddr,
    output nvc_prio_t                 rdata,
    // Parallel view
    output nvc_prio_arr_t             all
);

    nvc_prio_arr_t mem;

    genvar i;
    generate
        for (i = 0; i < `NVC_NSRC; i++) begin : g_ent
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    mem[i] <= `NVC_RST_PRIO;
                end else if (we && waddr == 5'(i)) begin
                    mem[i] <= wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= `NVC_RST_PRIO;
        end else begin
            rdata <= mem[raddr];
        end
    end

    assign all = mem;

endmodule

`default_nettype wire

// ### test/nvc_cpu_model.sv
// Processor core model facing the interrupt controller.
// Assumes the bench sets ack timing and asks for handler returns.
`timescale 1ns/1ps
`default_nettype none
`include "nvc_defs.svh"

module nvc_cpu_model
    import nvc_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Controller side
    input  wire nvc_cpu_req_t cpu,
    output logic              irq_ack,
    output logic              irq_done,
    // Bench control
    input  wire logic         ack_en,
    input  wire logic [1:0]   ack_dly,
    input  wire logic         retire,
    // Observation
    output logic [4:0]        taken_idx,
    output logic [31:0]       taken_vec,
    output logic [7:0]        taken_cnt
);
    logic [1:0] wait_cnt;
    logic [3:0] depth;
    logic       take;
    logic       ret;

    assign take = irq_ack & cpu.req;
    // Returns only as many handlers as were entered
    assign ret  = retire & ~irq_done & (depth != 4'h0);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_ack   <= 1'b0;
            irq_done  <= 1'b0;
            wait_cnt  <= 2'h0;
            depth     <= 4'h0;
            taken_idx <= 5'h0;
            taken_vec <= 32'h0;
            taken_cnt <= 8'h0;
        end else begin
            irq_ack  <= 1'b0;
            irq_done <= ret;
            wait_cnt <= 2'h0;
            // Slow answers stretch the wait while the request stands
            if (cpu.req && !irq_ack && ack_en) begin
                if (wait_cnt >= ack_dly) begin
                    irq_ack <= 1'b1;
                end else begin
                    wait_cnt <= wait_cnt + 2'h1;
                end
            end
            if (take) begin
                taken_idx <= cpu.index;
                taken_vec <= cpu.vector;
                taken_cnt <= taken_cnt + 8'h1;
            end
            depth <= depth + 4'(take) - 4'(ret);
        end
    end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the vectored interrupt controller.
// Assumes the rtl folder is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "nvc_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t mismatch got %0h exp %0h", $time, g, e); end end

module tb_top;
    import nvc_pkg::*;
    logic         clk, rst_b, wb_cyc, wb_stb, wb_we, wb_ack;
    logic         irq_ack, irq_done, sleep_on_exit, sleep_enter;
    logic         ack_en, retire, gate;
    logic [1:0]   ack_dly;
    logic [3:0]   wb_sel;
    logic [31:0]  wb_adr, wb_dat, wb_rdat, src_irq, taken_vec, q, d, en, m, vb;
    logic [4:0]   taken_idx;
    logic [7:0]   taken_cnt, c;
    logic [2:0]   thr;
    logic [2:0]   pr [32];
    logic [5:0]   e;
    logic [7:0]   ra [8];
    nvc_cpu_req_t cpu;
    int           failures, n_tests, n_sleep, i, g, j;
    integer       seed;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) if (sleep_enter === 1'b1) n_sleep++;

    nvc_ctrl DUT (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .src_irq(src_irq), .cpu(cpu),
        .irq_ack(irq_ack), .irq_done(irq_done), .sleep_on_exit(sleep_on_exit),
        .sleep_enter(sleep_enter));

    nvc_cpu_model cpu_m (.clk(clk), .rst_b(rst_b), .cpu(cpu), .irq_ack(irq_ack),
        .irq_done(irq_done), .ack_en(ack_en), .ack_dly(ack_dly), .retire(retire),
        .taken_idx(taken_idx), .taken_vec(taken_vec), .taken_cnt(taken_cnt));

    task automatic wrap_up();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One classic cycle; read data lands in q
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dw);
        int k;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= {24'h0, a};
        wb_dat <= dw;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack !== 1'b1 && k < 20);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (wb_ack !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t bus ack timeout", $time);
            wrap_up();
        end
        @(posedge clk);
    endtask

    task automatic wait_n(input logic [7:0] n);
        int k;
        for (k = 0; k < 40 && taken_cnt !== n; k++) @(posedge clk);
        if (taken_cnt !== n) begin
            failures++;
            $display("[FAIL] %0t dispatch timeout", $time);
            wrap_up();
        end
    endtask

    task automatic retire_one();
        retire <= 1'b1;
        @(posedge clk);
        retire <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // Most urgent candidate: lowest level, then lowest source number
    function automatic logic [5:0] best(input logic [31:0] mk);
        logic [5:0] r;
        r = 6'h0;
        for (int s = 0; s < 32; s++) begin
            if (mk[s] && (thr == 3'h0 || pr[s] < thr) && (!r[5] || pr[s] < pr[r[4:0]])) begin
                r = {1'b1, 5'(s)};
            end
        end
        return r;
    endfunction

    initial begin
        seed = 32'h1e0728d1;
        {wb_cyc, wb_stb, wb_we, ack_en, retire} = 5'h0;
        wb_sel = 4'hF;
        wb_adr = 32'h0;
        wb_dat = 32'h0;
        src_irq = 32'h0;
        ack_dly = 2'h0;
        gate = 1'b0;
        {failures, n_tests, n_sleep} = '0;
        ra = '{`NVC_A_EN_SET, `NVC_A_PEND_CLR, `NVC_A_ACTIVE, `NVC_A_CTRL,
               `NVC_A_THRESH, `NVC_A_VTBASE, `NVC_A_GATE_OPEN, 8'h30};
        rst_b = 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        `CHK(cpu, 38'h0)
        `CHK(sleep_on_exit, 1'b0)
        for (j = 0; j < 8; j++) begin
            xfer(1'b0, ra[j], 32'h0);
            `CHK(q, 32'h0)
        end
        xfer(1'b1, 8'h30, $random(seed));
        xfer(1'b0, 8'h30, 32'h0);
        `CHK(q, 32'h0)
        vb = $random(seed);
        xfer(1'b1, `NVC_A_VTBASE, vb);
        xfer(1'b0, `NVC_A_VTBASE, 32'h0);
        `CHK(q, {vb[31:10], 10'h0})
        // Arbitration with the core holding off; first rounds force ties
        for (i = 0; i < 12; i++) begin
            for (j = 0; j < 32; j++) begin
                d = (i < 2) ? 32'h60 : $random(seed);
                pr[j] = d[7:5];
                xfer(1'b1, `NVC_A_PRIO_LO + 8'(4 * j), d);
            end
            xfer(1'b0, `NVC_A_PRIO_LO + 8'(8 * i), 32'h0);
            `CHK(q, {24'h0, pr[2 * i], 5'h0})
            d = $random(seed);
            thr = (i < 3) ? 3'h0 : d[2:0];
            xfer(1'b1, `NVC_A_THRESH, {24'h0, thr, 5'h0});
            xfer(1'b0, `NVC_A_THRESH, 32'h0);
            `CHK(q[7:5], thr)
            d = $random(seed);
            en = ~d;
            xfer(1'b1, `NVC_A_EN_SET, 32'hFFFFFFFF);
            xfer(1'b1, `NVC_A_EN_CLR, d);
            xfer(1'b0, `NVC_A_EN_SET, 32'h0);
            `CHK(q, en)
            xfer(1'b0, `NVC_A_GATE_OPEN, 32'h0);
            `CHK(q[0], gate)
            gate = (i % 3 != 0);
            xfer(1'b1, gate ? `NVC_A_GATE_OPEN : `NVC_A_GATE_CLS, 32'h0);
            xfer(1'b0, `NVC_A_EN_CLR, 32'h0);
            `CHK(q, en)
            m = $random(seed);
            src_irq <= m;
            @(posedge clk);
            src_irq <= 32'h0;
            repeat (4) @(posedge clk);
            xfer(1'b0, `NVC_A_PEND_CLR, 32'h0);
            `CHK(q, m)
            e = best(m & en);
            `CHK(cpu.req, gate & e[5])
            if (gate && e[5]) begin
                `CHK(cpu.index, e[4:0])
                `CHK(cpu.vector, {vb[31:10], 3'h0, e[4:0], 2'h0})
            end
            xfer(1'b0, `NVC_A_VECTOR, 32'h0);
            `CHK(q, {vb[31:10], 3'h0, e[4:0], 2'h0})
            xfer(1'b0, `NVC_A_STATUS, 32'h0);
            `CHK(q, {gate & e[5], 10'h0, e[4:0], 12'h0, 4'h8})
            xfer(1'b1, `NVC_A_PEND_CLR, 32'hFFFFFFFF);
            repeat (2) @(posedge clk);
            `CHK(cpu.req, 1'b0)
            xfer(1'b0, `NVC_A_PEND_CLR, 32'h0);
            `CHK(q, 32'h0)
        end
        // Nesting against grouping: source 5 at level 2, source 9 at level 1
        xfer(1'b1, `NVC_A_EN_SET, 32'hFFFFFFFF);
        xfer(1'b1, `NVC_A_THRESH, 32'h0);
        xfer(1'b1, `NVC_A_PRIO_LO + 8'd20, 32'h40);
        xfer(1'b1, `NVC_A_PRIO_LO + 8'd36, 32'h20);
        ack_en <= 1'b1;
        for (g = 0; g < 8; g++) begin
            ack_dly <= 2'(g);
            xfer(1'b1, `NVC_A_CTRL, {21'h0, 3'(g), 6'h0, g == 7, 1'b1});
            xfer(1'b0, `NVC_A_CTRL, 32'h0);
            `CHK(q[10:8], 3'(g))
            `CHK(sleep_on_exit, g == 7)
            c = taken_cnt;
            xfer(1'b1, `NVC_A_PEND_SET, 32'h20);
            wait_n(c + 8'h1);
            `CHK(taken_idx, 5'd5)
            xfer(1'b1, `NVC_A_PEND_SET, 32'h200);
            repeat (8) @(posedge clk);
            `CHK(taken_cnt, 8'(c + 1 + (g >= 2)))
            if (g < 2) retire_one();
            wait_n(c + 8'h2);
            `CHK(taken_idx, 5'd9)
            `CHK(taken_vec, {vb[31:10], 3'h0, 5'd9, 2'h0})
            retire_one();
            if (g >= 2) retire_one();
        end
        `CHK(n_sleep, 1)
        wrap_up();
    end
endmodule
`default_nettype wire
